//--- common/acp_pkg.sv
// constants and types for the channel signal-path configuration block
// Contract
// (RULE1) each channel holds a reference select, first reference after reset
// (RULE2) host avoids inputs six and seven while a channel uses the second reference
// (RULE3) channel converts positive input selection minus negative input selection
// (RULE4) four differential channels on large variant, two on small variant
// (RULE5) seven single-ended channels on large variant, four on small variant
// (RULE6) input select fields carry the analog input number directly
// (RULE7) total gain is fixed stage (16x or bypass) times 1x, 2x, 4x or 8x
// (RULE8) each channel keeps its own gain select
// (RULE9) gain of 16 or more forces buffer in, else buffer-enable bit decides
// (RULE10) internal or external clock; detection mode stops oscillator once crystal seen
// (RULE11) results are 24-bit two's complement on the serial output
// (RULE12) output rate selectable from 1.6775 to 214.65 samples per second
// (RULE13) four-pin serial link: select_n, clock, data in, data out doubling as ready_n
// (RULE14) offset and gain correction on every result, gain trim of either sign
// (RULE15) ready_n pulses low once per result, 64 us slow rates, 4 us fast rates
package acp_pkg;
  localparam int CLK_MHZ = 200;
  localparam int MAX_CH = 7;
  localparam int CH_W = 3;
  localparam int RES_W = 24;
  localparam int TRIM_W = 16;
  localparam int TRIM_FRAC = 15;
  localparam int CMD_BITS = 8;
  localparam int DRDY_LONG_US = 64;
  localparam int DRDY_SHORT_US = 4;
  localparam int DRDY_LONG_CYC = DRDY_LONG_US * CLK_MHZ;
  localparam int DRDY_SHORT_CYC = DRDY_SHORT_US * CLK_MHZ;
  localparam int DRDY_CNT_W = 16;
  localparam int DIFF_CH_LARGE = 4;
  localparam int DIFF_CH_SMALL = 2;
  localparam int SE_CH_LARGE = 7;
  localparam int SE_CH_SMALL = 4;
  localparam logic [2:0] VIN_SHARED_LO = 3'h6;
  localparam logic [2:0] VIN_ABSENT_LO = 3'h3;
  localparam logic [2:0] VIN_ABSENT_HI = 3'h5;
  localparam logic [2:0] RATE_SLOW_MAX = 3'h3;
  localparam logic [2:0] RATE_DEFAULT = 3'h7;
  localparam logic [3:0] FIXED_GAIN_LOG2 = 4'h4;
  localparam logic [3:0] BUF_FORCE_LOG2 = 4'h4;
  localparam logic [RES_W-1:0] RES_MAX = 24'h7FFFFF;
  localparam logic [RES_W-1:0] RES_MIN = 24'h800000;

  typedef struct packed {
    logic [2:0] pos_sel;
    logic [2:0] neg_sel;
    logic ref2;
    logic fixed_on;
    logic [1:0] prog;
    logic buf_en;
    logic [2:0] rate;
  } acp_ch_cfg_t;

  localparam acp_ch_cfg_t CH_CFG_RST = '{3'h0, 3'h1, 1'b0, 1'b0, 2'h0, 1'b0, RATE_DEFAULT};

  typedef enum logic [1:0] {SPI_IDLE, SPI_CMD, SPI_DATA} acp_spi_t;
endpackage

//--- hw/acp_path_cfg.sv
// per-channel signal-path configuration, result correction and serial read-out
module acp_path_cfg #(
  parameter bit LARGE_VARIANT = 1'b1,
  parameter int DRDY_LONG_CYC = acp_pkg::DRDY_LONG_CYC,
  parameter int DRDY_SHORT_CYC = acp_pkg::DRDY_SHORT_CYC
) (
  input wire logic core_clk_i,
  input wire logic arst_n_i,
  input wire logic clk_en_i,
  input wire logic single_ended_i,
  input wire logic cfg_wr_i,
  input wire logic [acp_pkg::CH_W-1:0] cfg_ch_i,
  input wire acp_pkg::acp_ch_cfg_t cfg_data_i,
  output logic cfg_err_o,
  input wire logic [acp_pkg::CH_W-1:0] conv_ch_i,
  output logic [2:0] pos_sel_o,
  output logic [2:0] neg_sel_o,
  output logic ref2_sel_o,
  output logic fixed_gain_stage_o,
  output logic [1:0] programmable_gain_stage_o,
  output logic [3:0] gain_log2_o,
  output logic buf_in_path_o,
  output logic [2:0] output_sample_rate_o,
  input wire logic ext_detect_mode_i,
  input wire logic external_crystal_seen_i,
  output logic int_osc_on_o,
  output logic ext_clk_sel_o,
  input wire logic conv_valid_i,
  input wire logic [acp_pkg::RES_W-1:0] conv_raw_i,
  input wire logic [acp_pkg::RES_W-1:0] cal_offset_i,
  input wire logic [acp_pkg::TRIM_W-1:0] cal_gain_trim_i,
  output logic [acp_pkg::RES_W-1:0] result_o,
  input wire logic chip_select_n_i,
  input wire logic sclk_i,
  input wire logic sdi_i,
  output logic serial_out_or_ready_n_o,
  output logic serial_out_oe_o
);
  import acp_pkg::*;

  typedef struct packed {
    acp_ch_cfg_t [MAX_CH-1:0] cfg;
    logic [MAX_CH-1:0][RES_W-1:0] res;
    logic [3:0][1:0] sync;
    logic edge_hist;
    logic external_crystal_seen;
    logic cfg_err;
    acp_ch_cfg_t cur;
    logic [RES_W-1:0] result;
    logic [DRDY_CNT_W-1:0] drdy_cnt;
    acp_spi_t spi;
    logic [4:0] bitcnt;
    logic [CMD_BITS-1:0] cmd;
    logic [RES_W-1:0] shift;
  } acp_state_t;

  acp_state_t st_r, st_nxt;

  // true when an input number is missing on the small variant
  function automatic logic vin_absent(input logic [2:0] v);
    vin_absent = !LARGE_VARIANT && (v >= VIN_ABSENT_LO) && (v <= VIN_ABSENT_HI);
  endfunction

  // total gain as a power of two: fixed stage plus programmable stage
  function automatic logic [3:0] gain_log2(input acp_ch_cfg_t c);
    gain_log2 = (c.fixed_on ? FIXED_GAIN_LOG2 : 4'h0) + {2'h0, c.prog};
  endfunction

  logic [3:0] ch_limit;
  logic wr_bad;
  logic signed [RES_W:0] diff;
  logic signed [RES_W+TRIM_W:0] prod;
  logic signed [RES_W+1:0] corr;
  logic [RES_W-1:0] corr_sat;
  logic s_csn, s_sclk, s_sdi, sclk_rise, sclk_fall;

  // synchronised pins and edges, read from the second stage onward
  assign s_csn = st_r.sync[0][1];
  assign s_sclk = st_r.sync[1][1];
  assign s_sdi = st_r.sync[2][1];
  assign sclk_rise = s_sclk && !st_r.edge_hist;
  assign sclk_fall = !s_sclk && st_r.edge_hist;

  // channel count limit per variant and wiring mode
  always_comb begin
    if (single_ended_i) begin
      ch_limit = LARGE_VARIANT ? 4'(SE_CH_LARGE) : 4'(SE_CH_SMALL); // see RULE5
    end else begin
      ch_limit = LARGE_VARIANT ? 4'(DIFF_CH_LARGE) : 4'(DIFF_CH_SMALL); // see RULE4
    end
    wr_bad = ({1'b0, cfg_ch_i} >= ch_limit)
      || vin_absent(cfg_data_i.pos_sel) || vin_absent(cfg_data_i.neg_sel) // see RULE4
      || (cfg_data_i.ref2 && (cfg_data_i.pos_sel >= VIN_SHARED_LO
      || cfg_data_i.neg_sel >= VIN_SHARED_LO)); // see RULE2
  end

  // offset removal and signed gain trim, saturated to 24 bits
  always_comb begin
    diff = $signed({conv_raw_i[RES_W-1], conv_raw_i})
      - $signed({cal_offset_i[RES_W-1], cal_offset_i}); // see RULE14
    prod = diff * $signed(cal_gain_trim_i);
    corr = (RES_W+2)'(diff) + (RES_W+2)'(prod >>> TRIM_FRAC); // see RULE14
    if (corr > $signed((RES_W+2)'(RES_MAX)) ) begin
      corr_sat = RES_MAX;
    end else if (corr < -$signed((RES_W+2)'({1'b0, RES_MIN}))) begin
      corr_sat = RES_MIN;
    end else begin
      corr_sat = corr[RES_W-1:0]; // see RULE11
    end
  end

  // next-state logic for the whole block
  always_comb begin
    st_nxt = st_r;
    st_nxt.cfg_err = 1'b0;
    st_nxt.sync[0] = {st_r.sync[0][0], chip_select_n_i};
    st_nxt.sync[1] = {st_r.sync[1][0], sclk_i};
    st_nxt.sync[2] = {st_r.sync[2][0], sdi_i};
    st_nxt.sync[3] = {st_r.sync[3][0], external_crystal_seen_i};
    st_nxt.edge_hist = s_sclk;
    // configuration writes, refused ones flagged
    if (cfg_wr_i) begin
      if (wr_bad) begin
        st_nxt.cfg_err = 1'b1;
      end else begin
        st_nxt.cfg[cfg_ch_i] = cfg_data_i; // see RULE8
      end
    end
    // the converting channel's setup
    if (conv_ch_i < CH_W'(MAX_CH)) begin
      st_nxt.cur = st_r.cfg[conv_ch_i]; // see RULE3
    end
    // crystal detection latches until detection mode is left
    if (!ext_detect_mode_i) begin
      st_nxt.external_crystal_seen = 1'b0;
    end else if (st_r.sync[3][1]) begin
      st_nxt.external_crystal_seen = 1'b1; // see RULE10
    end
    // results and the ready pulse
    if (st_r.drdy_cnt != '0) begin
      st_nxt.drdy_cnt = st_r.drdy_cnt - DRDY_CNT_W'(1);
    end
    if (conv_valid_i && conv_ch_i < CH_W'(MAX_CH)) begin
      st_nxt.res[conv_ch_i] = corr_sat;
      st_nxt.result = corr_sat;
      st_nxt.drdy_cnt = (st_r.cfg[conv_ch_i].rate <= RATE_SLOW_MAX)
        ? DRDY_CNT_W'(DRDY_LONG_CYC) : DRDY_CNT_W'(DRDY_SHORT_CYC); // see RULE15
    end
    // serial frame: command byte in, 24-bit result out
    case (st_r.spi)
      SPI_IDLE: begin
        st_nxt.bitcnt = '0;
        if (!s_csn) begin
          st_nxt.spi = SPI_CMD;
        end
      end
      SPI_CMD: begin
        if (sclk_rise) begin
          st_nxt.cmd = {st_r.cmd[CMD_BITS-2:0], s_sdi}; // see RULE13
          st_nxt.bitcnt = st_r.bitcnt + 5'h1;
        end
        if (sclk_fall && st_r.bitcnt == 5'(CMD_BITS)) begin
          st_nxt.spi = SPI_DATA;
          st_nxt.bitcnt = '0;
          st_nxt.shift = (st_r.cmd[CH_W-1:0] < CH_W'(MAX_CH))
            ? st_r.res[st_r.cmd[CH_W-1:0]] : '0;
        end
      end
      SPI_DATA: begin
        if (sclk_fall) begin
          st_nxt.shift = {st_r.shift[RES_W-2:0], 1'b0}; // see RULE11
        end
      end
      default: st_nxt.spi = SPI_IDLE;
    endcase
    if (s_csn) begin
      st_nxt.spi = SPI_IDLE;
    end
  end

  // state register with clock enable
  always_ff @(posedge core_clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      st_r <= '0;
      st_r.cfg <= {MAX_CH{CH_CFG_RST}}; // see RULE1
      st_r.sync[0] <= '1; // select idles high, clock, data and crystal idle low
      st_r.cur <= CH_CFG_RST;
      st_r.spi <= SPI_IDLE;
    end else if (clk_en_i) begin
      st_r <= st_nxt;
    end
  end

  // outputs
  assign pos_sel_o = st_r.cur.pos_sel; // see RULE6
  assign neg_sel_o = st_r.cur.neg_sel; // see RULE6
  assign ref2_sel_o = st_r.cur.ref2; // see RULE1
  assign fixed_gain_stage_o = st_r.cur.fixed_on; // see RULE7
  assign programmable_gain_stage_o = st_r.cur.prog;
  assign gain_log2_o = gain_log2(st_r.cur); // see RULE7
  assign buf_in_path_o = (gain_log2(st_r.cur) >= BUF_FORCE_LOG2) || st_r.cur.buf_en; // see RULE9
  assign output_sample_rate_o = st_r.cur.rate; // see RULE12
  assign int_osc_on_o = !st_r.external_crystal_seen; // see RULE10
  assign ext_clk_sel_o = st_r.external_crystal_seen;
  assign cfg_err_o = st_r.cfg_err;
  assign result_o = st_r.result;
  assign serial_out_or_ready_n_o = (st_r.spi == SPI_DATA) ? st_r.shift[RES_W-1]
    : (st_r.drdy_cnt == '0); // see RULE13
  assign serial_out_oe_o = 1'b1;

  // checks
  a_buf_forced: assert property (@(posedge core_clk_i) disable iff (!arst_n_i) // see RULE9
    st_r.cur.fixed_on |-> buf_in_path_o) else $error("buffer not forced at high gain");
  a_gain_value: assert property (@(posedge core_clk_i) disable iff (!arst_n_i) // see RULE7
    gain_log2_o == {1'b0, st_r.cur.fixed_on, st_r.cur.prog})
    else $error("total gain wrong");
  a_ref_default: assert property (@(posedge core_clk_i) disable iff (!arst_n_i) // see RULE1
    $rose(arst_n_i) |-> !ref2_sel_o) else $error("reference not first after reset");
  a_bad_wr_flag: assert property (@(posedge core_clk_i) disable iff (!arst_n_i) // see RULE4
    clk_en_i && cfg_wr_i && {1'b0, cfg_ch_i} >= ch_limit |=> cfg_err_o)
    else $error("out-of-range channel write accepted");
  a_wr_store: assert property (@(posedge core_clk_i) disable iff (!arst_n_i) // see RULE6
    clk_en_i && cfg_wr_i && !wr_bad ##1 clk_en_i && conv_ch_i == $past(cfg_ch_i)
    |=> pos_sel_o == $past(cfg_data_i.pos_sel, 2)) else $error("config not applied");
  a_osc_off: assert property (@(posedge core_clk_i) disable iff (!arst_n_i) // see RULE10
    clk_en_i && ext_detect_mode_i && st_r.sync[3][1] |=> !int_osc_on_o)
    else $error("oscillator left on after detection");
  a_drdy_low: assert property (@(posedge core_clk_i) disable iff (!arst_n_i) // see RULE15
    clk_en_i && conv_valid_i && conv_ch_i < CH_W'(MAX_CH) && s_csn
    |=> !serial_out_or_ready_n_o) else $error("ready line not low after result");
  a_drdy_pulse: assert property (@(posedge core_clk_i) disable iff (!arst_n_i) // see RULE15
    clk_en_i && conv_valid_i && conv_ch_i < CH_W'(MAX_CH) |=> st_r.drdy_cnt != '0)
    else $error("ready pulse not started");
  a_result_sat: assert property (@(posedge core_clk_i) disable iff (!arst_n_i) // see RULE14
    clk_en_i && conv_valid_i && conv_ch_i < CH_W'(MAX_CH) |=> result_o == $past(corr_sat))
    else $error("result not captured");
  c_cfg_write: cover property (@(posedge core_clk_i) clk_en_i && cfg_wr_i && !wr_bad);
  c_result: cover property (@(posedge core_clk_i) conv_valid_i && clk_en_i);
  c_spi_data: cover property (@(posedge core_clk_i) st_r.spi == SPI_DATA);
endmodule

//--- verification/acp_spi_host.sv
// serial host model reading one stored result over the four-pin link
module acp_spi_host (
  output logic chip_select_n_o,
  output logic sclk_o,
  output logic sdi_o,
  input wire logic line_i
);
  timeunit 1ns;
  timeprecision 1ps;
  // idle: deselected, clock parked low
  initial begin
    chip_select_n_o = 1'b1;
    sclk_o = 1'b0;
    sdi_o = 1'b0;
  end
  // command byte msb first, then 24 bits, clock stands still outside
  task automatic read(input logic [7:0] cmd, output logic [23:0] data);
    chip_select_n_o = 1'b0;
    #40;
    for (int i = 7; i >= 0; i--) begin
      sdi_o = cmd[i];
      #40 sclk_o = 1'b1;
      #40 sclk_o = 1'b0;
    end
    for (int i = 23; i >= 0; i--) begin
      #40 data[i] = line_i;
      sclk_o = 1'b1;
      #40 sclk_o = 1'b0;
    end
    #40 chip_select_n_o = 1'b1;
    sdi_o = ~sdi_o; // released line shows no stale value
  endtask
endmodule

//--- verification/tb.sv
// self-checking bench for the channel path configuration block
`define CHK(n, e, g) begin compares++; if ((g) !== (e)) begin errors++; \
  $display("FAIL %s exp %0h got %0h", n, e, g); end end
module tb;
  timeunit 1ns;
  timeprecision 1ps;
  import acp_pkg::*;
  logic clk = 0, arst_n = 0, se = 0, wr = 0, det = 0, xs = 0, cv = 0, ce = 1;
  logic [2:0] wch = 0, cch = 0, ps, ns, rate;
  acp_ch_cfg_t cd = CH_CFG_RST;
  logic [23:0] raw = 0, off = 0, res, rd;
  logic [15:0] trim = 0;
  logic err, r2, fg, buf_o, osc, ext, line, oe, csn, sck, sdi;
  logic [1:0] pg;
  logic [3:0] gl;
  int errors = 0, compares = 0;
  always #2.5 clk = ~clk;
  acp_path_cfg #(.DRDY_LONG_CYC(20), .DRDY_SHORT_CYC(5)) i_acp_path_cfg (
    .core_clk_i(clk), .arst_n_i(arst_n), .clk_en_i(ce), .single_ended_i(se),
    .cfg_wr_i(wr), .cfg_ch_i(wch), .cfg_data_i(cd), .cfg_err_o(err), .conv_ch_i(cch),
    .pos_sel_o(ps), .neg_sel_o(ns), .ref2_sel_o(r2), .fixed_gain_stage_o(fg),
    .programmable_gain_stage_o(pg), .gain_log2_o(gl), .buf_in_path_o(buf_o),
    .output_sample_rate_o(rate), .ext_detect_mode_i(det), .external_crystal_seen_i(xs),
    .int_osc_on_o(osc), .ext_clk_sel_o(ext), .conv_valid_i(cv), .conv_raw_i(raw),
    .cal_offset_i(off), .cal_gain_trim_i(trim), .result_o(res),
    .chip_select_n_i(csn), .sclk_i(sck), .sdi_i(sdi),
    .serial_out_or_ready_n_o(line), .serial_out_oe_o(oe));
  acp_spi_host i_acp_spi_host (.chip_select_n_o(csn), .sclk_o(sck), .sdi_o(sdi),
    .line_i(line));
  // one configuration write, refusal flag looked at in its cycle
  task automatic cfg(input logic [2:0] ch, input acp_ch_cfg_t d, input logic e);
    @(negedge clk) begin wch = ch; cd = d; wr = 1'b1; end
    @(negedge clk) wr = 1'b0;
    `CHK("cfg_err", e, err)
  endtask
  // select a channel and compare its routed setup
  task automatic look(input logic [2:0] ch, input logic [13:0] e, input logic [4:0] g);
    cch = ch;
    repeat (2) @(negedge clk);
    `CHK("setup", e, {ps, ns, r2, fg, pg, buf_o, rate})
    `CHK("gain", g, {gl, buf_o})
  endtask
  // one conversion: corrected result, then ready pulse length
  task automatic conv(input logic [2:0] ch, input logic [23:0] r, o, input logic [15:0] t,
      input logic [23:0] e, input int n);
    int k;
    k = 0;
    @(negedge clk) begin cch = ch; raw = r; off = o; trim = t; cv = 1'b1; end
    @(negedge clk) cv = 1'b0;
    `CHK("result", e, res)
    while (line === 1'b0 && k < 100) begin k++; @(negedge clk); end
    `CHK("ready_len", n, k)
  endtask
  task automatic t_reset();
    `CHK("rst_cfg", CH_CFG_RST, {ps, ns, r2, fg, pg, buf_o, rate})
    `CHK("rst_out", {4'h0, 4'h9, 1'b1, 24'h0}, {gl, osc, ext, err, line, oe, res})
    @(negedge clk) arst_n = 1'b1;
    $display("t_reset done");
  endtask
  task automatic t_paths();
    cfg(3'h0, '{3'h4, 3'h1, 1'b1, 1'b1, 2'h3, 1'b0, 3'h2}, 1'b0);
    cfg(3'h1, '{3'h2, 3'h0, 1'b0, 1'b0, 2'h1, 1'b1, 3'h5}, 1'b0);
    cfg(3'h2, '{3'h0, 3'h3, 1'b0, 1'b0, 2'h3, 1'b0, 3'h0}, 1'b0);
    look(3'h0, 14'b100_001_1_1_11_1_010, 5'b0111_1);
    look(3'h1, 14'b010_000_0_0_01_1_101, 5'b0001_1);
    look(3'h2, 14'b000_011_0_0_11_0_000, 5'b0011_0);
    $display("t_paths done");
  endtask
  task automatic t_refuse();
    cfg(3'h3, '{3'h6, 3'h1, 1'b1, 1'b0, 2'h0, 1'b0, 3'h0}, 1'b1);
    cfg(3'h3, '{3'h2, 3'h7, 1'b1, 1'b0, 2'h0, 1'b0, 3'h0}, 1'b1);
    cfg(3'h4, '{3'h2, 3'h3, 1'b0, 1'b0, 2'h1, 1'b1, 3'h4}, 1'b1);
    look(3'h4, CH_CFG_RST, 5'b0000_0);
    cfg(3'h3, CH_CFG_RST, 1'b0);
    se = 1'b1;
    cfg(3'h6, '{3'h6, 3'h0, 1'b0, 1'b0, 2'h0, 1'b0, 3'h1}, 1'b0);
    cfg(3'h7, CH_CFG_RST, 1'b1);
    look(3'h6, 14'b110_000_0_0_00_0_001, 5'b0000_0);
    look(3'h0, 14'b100_001_1_1_11_1_010, 5'b0111_1);
    $display("t_refuse done");
  endtask
  task automatic t_conv();
    conv(3'h0, 24'h000100, 24'h000010, 16'h4000, 24'h000168, 20);
    conv(3'h1, 24'hFFFF00, 24'h000000, 16'h0000, 24'hFFFF00, 5);
    conv(3'h0, 24'h7FFFF0, 24'hFFFFF0, 16'h0000, 24'h7FFFFF, 20);
    conv(3'h1, 24'h800010, 24'h000020, 16'h0000, 24'h800000, 5);
    i_acp_spi_host.read(8'h01, rd);
    `CHK("serial", 24'h800000, rd)
    $display("t_conv done");
  endtask
  task automatic t_clock();
    @(negedge clk) xs = 1'b1;
    repeat (6) @(negedge clk);
    `CHK("osc_nodet", 2'b10, {osc, ext})
    det = 1'b1;
    repeat (6) @(negedge clk);
    `CHK("osc_det", 2'b01, {osc, ext})
    $display("t_clock done");
  endtask
  // reset in mid-run brings channel 0 back to its defaults and the oscillator back on
  task automatic t_rearm();
    @(negedge clk) arst_n = 1'b0;
    @(negedge clk) `CHK("osc_rst", 2'b10, {osc, ext})
    arst_n = 1'b1;
    look(3'h0, CH_CFG_RST, 5'b0000_0);
    $display("t_rearm done");
  endtask
  // a write while the clock enable is low must not land
  task automatic t_hold();
    ce = 1'b0;
    cfg(3'h1, '{3'h5, 3'h2, 1'b0, 1'b1, 2'h0, 1'b1, 3'h3}, 1'b0);
    ce = 1'b1;
    look(3'h1, CH_CFG_RST, 5'b0000_0);
    $display("t_hold done");
  endtask
  task automatic give_verdict();
    $display("compares %0d errors %0d", compares, errors);
    if (errors == 0 && compares > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask
  // main sequence
  initial begin
    repeat (3) @(negedge clk);
    t_reset();
    t_paths();
    t_refuse();
    t_conv();
    t_clock();
    t_rearm();
    t_hold();
    give_verdict();
  end
  // watchdog
  initial begin
    #60000;
    errors++;
    give_verdict();
  end
endmodule
